/* File: common/iscr_pkg.sv */
package iscr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_MIN_RES  = 8'h03;
  localparam logic [7:0] OFS_AMP_RESP = 8'h04;
  localparam logic [7:0] OFS_CNT_REF  = 8'h05;
  localparam logic [7:0] OFS_UTH_LO   = 8'h06;
  localparam logic [7:0] OFS_UTH_HI   = 8'h07;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  RST_MIN_RES  = 8'h45;
  localparam logic [7:0]  RST_AMP_RESP = 8'h1B;
  localparam logic [7:0]  RST_CNT_REF  = 8'h01;
  localparam logic [7:0]  RST_UTH_LO   = 8'hFF;
  localparam logic [7:0]  RST_UTH_HI   = 8'hFF;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int         AMP_LSB       = 3;
  localparam int         RESP_LSB      = 0;
  localparam int         REF_SEL_BIT   = 1;
  localparam int         PD_BIT        = 0;
  localparam logic [7:0] AMP_RESP_MASK = 8'h1F;
  localparam logic [7:0] CNT_REF_MASK  = 8'h03;

  // ****************************************
  // field encodings
  // ****************************************
  typedef enum logic [1:0] {
    ISCR_AMP_1V  = 2'h0,
    ISCR_AMP_2V  = 2'h1,
    ISCR_AMP_4V  = 2'h2,
    ISCR_AMP_RSV = 2'h3
  } iscr_amp_t;

  localparam logic [2:0] RESP_MIN_LEGAL = 3'h2;

  // ****************************************
  // register access carrier
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iscr_req_t;

  // ****************************************
  // configuration carried to the converter
  // ****************************************
  typedef struct packed {
    logic [7:0]  min_res_code;
    iscr_amp_t   amplitude;
    logic [2:0]  resp_code;
    logic        ref_is_crystal;
    logic        timebase_powerdown;
    logic [15:0] upper_threshold;
  } iscr_cfg_t;

endpackage : iscr_pkg

/* File: rtl/iscr_regs.sv */
`timescale 1ns/1ps
// What this block does
// - Read/write byte at 0x03 holds minimum resonance code, resets to 0x45.
// - Bits 4-3 at 0x04 pick amplitude 1V/2V/4V; code 11 reserved.
// - Bits 2-0 pick response length 192..6144; codes 000 and 001 reserved.
// - Register 0x04 resets to 0x1B; bits 7-5 read zero.
// - Bit 1 at 0x05: one picks crystal, zero picks time-base clock input.
// - Bit 0 at 0x05 set powers down crystal and disables time-base clock.
// - Register 0x05 resets to 0x01; bits 7-2 read zero.
// - Writing 0x06 loads only a holding buffer, not the live threshold.
// - Reading 0x06 returns live threshold bits 7:0, not the buffer.
// - Register 0x06 resets to 0xFF.
// - Register 0x07 maps to threshold 15:8; threshold resets to 0xFFFF.
// - Writing 0x07 commits written byte and buffered low byte together.
module iscr_regs (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // register access
  input  wire iscr_pkg::iscr_req_t req,
  output logic [7:0]              rdata,
  output logic                    addr_hit,
  // configuration to the converter
  output iscr_pkg::iscr_cfg_t     cfg,
  output logic                    cfg_illegal
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_q;
  wire  rst_n = rst_sync_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  wire sel_min  = (req.addr == iscr_pkg::OFS_MIN_RES);
  wire sel_amp  = (req.addr == iscr_pkg::OFS_AMP_RESP);
  wire sel_ref  = (req.addr == iscr_pkg::OFS_CNT_REF);
  wire sel_lo   = (req.addr == iscr_pkg::OFS_UTH_LO);
  wire sel_hi   = (req.addr == iscr_pkg::OFS_UTH_HI);
  wire wr_min   = req.wr & sel_min;
  wire wr_amp   = req.wr & sel_amp;
  wire wr_ref   = req.wr & sel_ref;
  wire wr_lo    = req.wr & sel_lo;
  wire wr_hi    = req.wr & sel_hi;

  assign addr_hit = sel_min | sel_amp | sel_ref | sel_lo | sel_hi;

  unmapped_write_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.wr && !addr_hit) |=> $stable(cfg))
    else $error("unmapped write changed configuration");

  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  min_res_q;
  logic [7:0]  amp_resp_q;
  logic [7:0]  cnt_ref_q;
  logic [7:0]  lo_buf_q;
  logic [15:0] uth_q;

  wire [7:0]  min_res_d  = wr_min ? req.wdata : min_res_q;
  wire [7:0]  amp_resp_d = wr_amp ? (req.wdata & iscr_pkg::AMP_RESP_MASK) : amp_resp_q;
  wire [7:0]  cnt_ref_d  = wr_ref ? (req.wdata & iscr_pkg::CNT_REF_MASK) : cnt_ref_q;
  wire [7:0]  lo_buf_d   = wr_lo ? req.wdata : lo_buf_q;
  wire [15:0] uth_d      = wr_hi ? {req.wdata, lo_buf_q} : uth_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      min_res_q  <= iscr_pkg::RST_MIN_RES;
      amp_resp_q <= iscr_pkg::RST_AMP_RESP;
      cnt_ref_q  <= iscr_pkg::RST_CNT_REF;
      lo_buf_q   <= iscr_pkg::RST_UTH_LO;
      uth_q      <= {iscr_pkg::RST_UTH_HI, iscr_pkg::RST_UTH_LO};
    end else begin
      min_res_q  <= min_res_d;
      amp_resp_q <= amp_resp_d;
      cnt_ref_q  <= cnt_ref_d;
      lo_buf_q   <= lo_buf_d;
      uth_q      <= uth_d;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] rd_mux =
      sel_min ? min_res_q :
      sel_amp ? amp_resp_q :
      sel_ref ? cnt_ref_q :
      sel_lo  ? uth_q[7:0] :
      sel_hi  ? uth_q[15:8] :
      8'h00;

  assign rdata = req.rd ? rd_mux : 8'h00;

  idle_read_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !req.rd |-> (rdata == 8'h00))
    else $error("read data not zero while idle");

  unmapped_read_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.rd && !addr_hit) |-> (rdata == 8'h00))
    else $error("unmapped read not zero");

  hi_read_live_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.rd && sel_hi) |-> (rdata == uth_q[15:8]))
    else $error("high byte read not live threshold");

  amp_read_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.rd && sel_amp) |-> (rdata[7:5] == 3'h0))
    else $error("amplitude register reserved bits read nonzero");

  ref_read_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.rd && sel_ref) |-> (rdata[7:2] == 6'h00))
    else $error("reference register reserved bits read nonzero");

  // ****************************************
  // configuration outputs
  // ****************************************
  wire [1:0] amp_code  = amp_resp_q[iscr_pkg::AMP_LSB +: 2];
  wire [2:0] resp_code = amp_resp_q[iscr_pkg::RESP_LSB +: 3];

  assign cfg.min_res_code       = min_res_q;
  assign cfg.amplitude          = iscr_pkg::iscr_amp_t'(amp_code);
  assign cfg.resp_code          = resp_code;
  assign cfg.ref_is_crystal     = cnt_ref_q[iscr_pkg::REF_SEL_BIT];
  assign cfg.timebase_powerdown = cnt_ref_q[iscr_pkg::PD_BIT];
  assign cfg.upper_threshold    = uth_q;

  // reserved codes flagged, host must avoid them
  assign cfg_illegal = (amp_code == iscr_pkg::ISCR_AMP_RSV) |
                       (resp_code < iscr_pkg::RESP_MIN_LEGAL);

  // ****************************************
  // checks
  // ****************************************
  lo_buffer_only_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_lo && !wr_hi) |=> (uth_q == $past(uth_q)))
    else $error("low byte write changed live threshold");

  hi_commit_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_hi |=> (uth_q == {$past(req.wdata), $past(lo_buf_q)}))
    else $error("high byte write did not commit both bytes");

  lo_read_live_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (req.rd && sel_lo) |-> (rdata == uth_q[7:0]))
    else $error("low byte read not live threshold");

  amp_resv_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    amp_resp_q[7:5] == 3'h0)
    else $error("amplitude register reserved bits set");

  ref_resv_zero_a : assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_ref_q[7:2] == 6'h00)
    else $error("reference register reserved bits set");

  min_write_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_min |=> (cfg.min_res_code == $past(req.wdata)))
    else $error("minimum resonance code not written");

  ref_sel_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ref |=> (cfg.ref_is_crystal == $past(req.wdata[1])))
    else $error("reference select not updated");

  pd_write_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ref |=> (cfg.timebase_powerdown == $past(req.wdata[0])))
    else $error("power-down bit not updated");

  reset_vals_a : assert property (@(posedge mclk)
    $rose(rst_n) |-> (uth_q == {iscr_pkg::RST_UTH_HI, iscr_pkg::RST_UTH_LO} && lo_buf_q == iscr_pkg::RST_UTH_LO &&
                      amp_resp_q == iscr_pkg::RST_AMP_RESP && cnt_ref_q == iscr_pkg::RST_CNT_REF &&
                      min_res_q == iscr_pkg::RST_MIN_RES))
    else $error("reset values wrong");

  resp_field_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_amp |=> (cfg.resp_code == $past(req.wdata[2:0])))
    else $error("response field not updated");

  amp_resv_flag_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.amplitude == iscr_pkg::ISCR_AMP_RSV) |-> cfg_illegal)
    else $error("reserved amplitude not flagged");

  resp_resv_flag_a : assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.resp_code < iscr_pkg::RESP_MIN_LEGAL) |-> cfg_illegal)
    else $error("reserved response code not flagged");

  legal_clear_a : assert property (@(posedge mclk) disable iff (!rst_n)
    ((cfg.amplitude != iscr_pkg::ISCR_AMP_RSV) && (cfg.resp_code >= iscr_pkg::RESP_MIN_LEGAL)) |-> !cfg_illegal)
    else $error("legal configuration flagged");

  amp_write_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_amp |=> (cfg.amplitude == $past(req.wdata[iscr_pkg::AMP_LSB +: 2])))
    else $error("amplitude field not updated");

  lo_write_buf_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_lo |=> (lo_buf_q == $past(req.wdata)))
    else $error("low byte write not buffered");

  min_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_min |=> $stable(min_res_q))
    else $error("minimum resonance code changed without write");

  thresh_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_hi |=> $stable(uth_q))
    else $error("live threshold changed without high byte write");

endmodule : iscr_regs

/* File: tb/iscr_host.sv */
`timescale 1ns/1ps
// ****************************************
// host side of the register strobes
// ****************************************
module iscr_host (
  // clock
  input  wire logic                mclk,
  // register access
  output iscr_pkg::iscr_req_t      req,
  input  wire logic [7:0]          rdata,
  input  wire logic                addr_hit
);
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  // called just after an edge, returns just after the next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge mclk);
    d = rdata;
    h = addr_hit;
    #1;
  endtask : rd
  // released lines flip so stale values never look valid
  task automatic idle();
    req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
    @(posedge mclk) #1;
  endtask : idle
  function automatic logic [7:0] res_code(input real f_hz);
    return 8'(int'(68.94 * $log10(f_hz / 2000.0)));
  endfunction : res_code
endmodule : iscr_host

/* File: tb/inductive_sense_config_regs_tb.sv */
`timescale 1ns/1ps
module inductive_sense_config_regs_tb;
  logic                mclk = 1'b0;
  logic                rstn = 1'b0;
  iscr_pkg::iscr_req_t req;
  logic [7:0]          rdata;
  logic                addr_hit;
  iscr_pkg::iscr_cfg_t cfg;
  logic                cfg_illegal;
  int                  err_total = 0;
  int                  comparisons = 0;
  logic [7:0]          d;
  logic                h;
  initial forever #50 mclk = ~mclk;
  iscr_regs iscr_regs_i (.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .addr_hit(addr_hit), .cfg(cfg),
                         .cfg_illegal(cfg_illegal));
  iscr_host iscr_host_i (.mclk(mclk), .req(req), .rdata(rdata), .addr_hit(addr_hit));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    iscr_host_i.rd(a, d, h);
    check($sformatf("rdata at %h", a), {8'h00, d}, {8'h00, exp});
    check($sformatf("hit at %h", a), 16'(h), 16'(a >= iscr_pkg::OFS_MIN_RES && a <= iscr_pkg::OFS_UTH_HI));
  endtask : rdchk
  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) @(posedge mclk);
    check("threshold in reset", cfg.upper_threshold, 16'hFFFF);
    #1 rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : do_reset
  task automatic test_reset();
    rdchk(8'h03, 8'h45);
    rdchk(8'h04, 8'h1B);
    rdchk(8'h05, 8'h01);
    rdchk(8'h06, 8'hFF);
    rdchk(8'h07, 8'hFF);
    iscr_host_i.idle();
    $display("reset values done");
  endtask : test_reset
  task automatic test_fields();
    for (int a = 0; a < 3; a++) begin
      for (int r = 2; r < 8; r++) begin
        iscr_host_i.wr(8'h04, 8'((a << 3) | r));
        check("amplitude", 16'(cfg.amplitude), 16'(a));
        check("resp code", 16'(cfg.resp_code), 16'(r));
        check("legal", 16'(cfg_illegal), 16'h0000);
      end
    end
    iscr_host_i.wr(8'h04, 8'hFF);
    check("amp 11 flagged", 16'(cfg_illegal), 16'h0001);
    rdchk(8'h04, 8'h1F);
    iscr_host_i.wr(8'h04, 8'h01);
    check("resp 001 flagged", 16'(cfg_illegal), 16'h0001);
    for (int c = 0; c < 4; c++) begin
      iscr_host_i.wr(8'h05, 8'hFC | 8'(c));
      check("crystal sel", 16'(cfg.ref_is_crystal), 16'(c >> 1));
      check("powerdown", 16'(cfg.timebase_powerdown), 16'(c & 1));
      rdchk(8'h05, 8'(c));
    end
    iscr_host_i.wr(8'h03, iscr_host_i.res_code(800000.0));
    check("min code", 16'(cfg.min_res_code), 16'h00B3);
    rdchk(8'h03, 8'hB3);
    iscr_host_i.idle();
    $display("field tests done");
  endtask : test_fields
  task automatic test_threshold();
    iscr_host_i.wr(8'h06, 8'h34);
    check("after low byte", cfg.upper_threshold, 16'hFFFF);
    iscr_host_i.wr(8'h07, 8'h12);
    check("commit", cfg.upper_threshold, 16'h1234);
    rdchk(8'h06, 8'h34);
    rdchk(8'h07, 8'h12);
    iscr_host_i.wr(8'h06, 8'hAB);
    rdchk(8'h06, 8'h34);
    iscr_host_i.wr(8'h07, 8'h56);
    check("buffered commit", cfg.upper_threshold, 16'h56AB);
    iscr_host_i.wr(8'h08, 8'h77);
    rdchk(8'h08, 8'h00);
    check("unmapped hit", 16'(h), 16'h0000);
    iscr_host_i.idle();
    $display("threshold tests done");
  endtask : test_threshold
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    do_reset();
    test_reset();
    test_fields();
    test_threshold();
    do_reset();
    test_reset();
    tally_and_finish();
  end
endmodule : inductive_sense_config_regs_tb
